// ==== core/status_sleep_defines.svh ====
// What this block does
// - Command 0Eh returns one signal-mode status byte, D7 first.
// - Signal-mode bits D7, D6 and D1 always read zero.
// - Signal-mode D5 follows the horizontal sync flag.
// - Signal-mode D4 follows the vertical sync flag.
// - Signal-mode D3 follows the pixel clock line level.
// - Signal-mode D2 follows the data enable flag.
// - Both status reads are answered in every power state.
// - Command 0Fh returns one self-diagnostic result byte, D7 first.
// - Diagnostic D7 register load, D6 functionality; D5 to D1 read zero.
// - Diagnostic D0 is one when checksums differ, zero when equal.
// - Command 10h, no parameters, enters the lowest-power sleep state.
// - Asleep: converter off, oscillator stopped, panel scanning halted.
// - Sleep entry ignored when asleep; only command 11h leaves sleep.
// - Sleep entry completes about 120 ms after the command; up to 160 ms when no pixel frames arrive.
// - Entry order: blank, drain panel, stop converter, stop oscillator, sleep.
// - Source outputs blank for over one frame before the shutdown.
`ifndef STATUS_SLEEP_DEFINES_SVH
`define STATUS_SLEEP_DEFINES_SVH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define CMD_SW_RESET 8'h01
`define CMD_READ_SIGNAL_MODE 8'h0e
`define CMD_READ_SELF_DIAG 8'h0f
`define CMD_SLEEP_ENTRY 8'h10
`define CMD_SLEEP_EXIT 8'h11

// ----------------------------------------------------------------
// Status byte fields and reset values
// ----------------------------------------------------------------
`define SM_HSYNC_BIT 5
`define SM_VSYNC_BIT 4
`define SM_PCLK_BIT 3
`define SM_DE_BIT 2
`define DIAG_REG_LOAD_BIT 7
`define DIAG_FUNC_BIT 6
`define DIAG_CHECKSUM_BIT 0
`define SIGNAL_MODE_RESET 8'h00
`define SELF_DIAG_RESET 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLOCK_HZ 40000000
`define HZ_PER_MHZ 1000000
`define TICK_CYCLES (`CLOCK_HZ / `HZ_PER_MHZ)
`define SLEEP_ENTRY_TIME_US 120000
`define BLANK_TIME_US 40000
`define DRAIN_TIME_US 40000
`define DCDC_OFF_TIME_US 20000
`define OSC_OFF_TIME_US 20000
`define FRAMES_BEFORE_SHUTDOWN 2
`define TIMER_WIDTH 18

`endif

// ==== core/status_sleep_pkg.sv ====
package status_sleep_pkg;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef logic [7:0] status_byte_t;

    typedef enum logic [2:0]
    {
        ST_ASLEEP,
        ST_AWAKE,
        ST_BLANK,
        ST_DRAIN,
        ST_DCDC_OFF,
        ST_OSC_OFF
    } sleep_state_t;

endpackage : status_sleep_pkg

// ==== core/sleep_delay_timer.sv ====
module sleep_delay_timer
#(
    parameter int unsigned COUNT_W = 18,
    parameter int unsigned TICK_DIV = 40
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_load,
    input wire logic [COUNT_W-1:0] i_count,
    output logic o_expired
);

    localparam int unsigned DIV_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    generate
        if (TICK_DIV < 1 || COUNT_W < 2)
        begin : g_bad_params
            $error("timer tick divider or count width too small");
        end
    endgenerate

    logic [DIV_W-1:0] div_q;
    logic tick_us;
    logic [COUNT_W-1:0] remain_q;
    logic running_q;

    // Microsecond enable, restarted on load so delays are exact
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n || i_load || div_q == DIV_LAST)
            div_q <= '0;
        else
            div_q <= div_q + 1'b1;
    end

    assign tick_us = (div_q == DIV_LAST);

    // Countdown in microseconds, one pulse at zero
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            remain_q <= '0;
            running_q <= 1'b0;
            o_expired <= 1'b0;
        end
        else if (i_load)
        begin
            remain_q <= i_count;
            running_q <= 1'b1;
            o_expired <= 1'b0;
        end
        else if (running_q && tick_us)
        begin
            remain_q <= remain_q - 1'b1;
            running_q <= (remain_q > COUNT_W'(1));
            o_expired <= (remain_q <= COUNT_W'(1));
        end
        else
        begin
            o_expired <= 1'b0;
        end
    end

endmodule : sleep_delay_timer

// ==== core/status_readback_and_sleep_entry.sv ====
`include "status_sleep_defines.svh"

module status_readback_and_sleep_entry
#(
    parameter int unsigned BLANK_US = `BLANK_TIME_US,
    parameter int unsigned DRAIN_US = `DRAIN_TIME_US,
    parameter int unsigned DCDC_OFF_US = `DCDC_OFF_TIME_US,
    parameter int unsigned OSC_OFF_US = `OSC_OFF_TIME_US,
    parameter int unsigned TICK_DIV = `TICK_CYCLES
)
(
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    // Decoded command bytes from the serial front end
    input wire logic I_CMD_VALID,
    input wire logic [7:0] I_CMD_CODE,
    // Pixel interface pins
    input wire logic I_HSYNC,
    input wire logic I_VSYNC,
    input wire logic I_PCLK,
    input wire logic I_DE,
    // Results of the self-diagnostic engine
    input wire logic I_DIAG_VALID,
    input wire logic I_DIAG_REG_LOAD,
    input wire logic I_DIAG_FUNC,
    input wire logic I_DIAG_CHECKSUM_DIFF,
    // Read answer
    output logic O_RD_VALID,
    output status_sleep_pkg::status_byte_t O_RD_DATA,
    // Power and panel control
    output logic O_DCDC_EN,
    output logic O_OSC_EN,
    output logic O_SCAN_EN,
    output logic O_SOURCE_BLANK,
    output logic O_PANEL_DRAIN,
    output logic O_ASLEEP,
    output logic O_SLEEP_BUSY
);

    import status_sleep_pkg::*;

    localparam int unsigned TMR_W = `TIMER_WIDTH;
    localparam logic [TMR_W-1:0] BLANK_LOAD = TMR_W'(BLANK_US);
    localparam logic [TMR_W-1:0] DRAIN_LOAD = TMR_W'(DRAIN_US);
    localparam logic [TMR_W-1:0] DCDC_LOAD = TMR_W'(DCDC_OFF_US);
    localparam logic [TMR_W-1:0] OSC_LOAD = TMR_W'(OSC_OFF_US);
    localparam logic [1:0] FRAMES_NEEDED = 2'(`FRAMES_BEFORE_SHUTDOWN);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    generate
        if (BLANK_US < 1 || DRAIN_US < 1 || DCDC_OFF_US < 1 || OSC_OFF_US < 1 ||
            BLANK_US >= (1 << TMR_W) || DRAIN_US >= (1 << TMR_W) || TICK_DIV < 1 ||
            DCDC_OFF_US >= (1 << TMR_W) || OSC_OFF_US >= (1 << TMR_W))
        begin : g_bad_params
            $error("phase time or tick divider out of range");
        end
    endgenerate

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int unsigned NPINS = 4;

    logic [NPINS-1:0] pin_raw;
    logic [NPINS-1:0] pin_meta_q;
    logic [NPINS-1:0] pin_sync_q;

    assign pin_raw = {I_DE, I_PCLK, I_VSYNC, I_HSYNC};

    // Two flops per pin; only the second stage is read
    generate
        for (genvar p = 0; p < NPINS; p++)
        begin : g_pin_sync
            always_ff @(posedge I_CLOCK)
            begin
                if (!I_RST_N)
                begin
                    pin_meta_q[p] <= 1'b0;
                    pin_sync_q[p] <= 1'b0;
                end
                else
                begin
                    pin_meta_q[p] <= pin_raw[p];
                    pin_sync_q[p] <= pin_meta_q[p];
                end
            end
        end
    endgenerate

    wire logic hsync_flag = pin_sync_q[0];
    wire logic vsync_flag = pin_sync_q[1];
    wire logic pclk_level = pin_sync_q[2];
    wire logic data_enable_flag = pin_sync_q[3];

    // Previous vertical sync level for frame start detection
    logic vsync_prev_q;
    logic frame_start;

    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RST_N)
            vsync_prev_q <= 1'b0;
        else
            vsync_prev_q <= vsync_flag;
    end

    assign frame_start = vsync_flag && !vsync_prev_q;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic read_signal_mode_cmd;
    logic read_self_diag_cmd;
    logic sleep_entry_cmd;
    logic sleep_exit_cmd;
    logic sw_reset_cmd;

    // Status reads decode regardless of power state
    always_comb
    begin
        read_signal_mode_cmd = I_CMD_VALID && (I_CMD_CODE == `CMD_READ_SIGNAL_MODE);
        read_self_diag_cmd = I_CMD_VALID && (I_CMD_CODE == `CMD_READ_SELF_DIAG);
        sleep_entry_cmd = I_CMD_VALID && (I_CMD_CODE == `CMD_SLEEP_ENTRY);
        sleep_exit_cmd = I_CMD_VALID && (I_CMD_CODE == `CMD_SLEEP_EXIT);
        sw_reset_cmd = I_CMD_VALID && (I_CMD_CODE == `CMD_SW_RESET);
    end

    // ------------------------------------------------------------
    // Status bytes
    // ------------------------------------------------------------
    status_byte_t signal_mode_status;
    status_byte_t self_diagnostic_result_q;

    // Live interface state; tearing bits and D1/D0 held at zero
    always_comb
    begin
        signal_mode_status = `SIGNAL_MODE_RESET;
        signal_mode_status[`SM_HSYNC_BIT] = hsync_flag;
        signal_mode_status[`SM_VSYNC_BIT] = vsync_flag;
        signal_mode_status[`SM_PCLK_BIT] = pclk_level;
        signal_mode_status[`SM_DE_BIT] = data_enable_flag;
    end

    // Diagnostic result captured from the self-check engine
    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RST_N || sw_reset_cmd)
        begin
            self_diagnostic_result_q <= `SELF_DIAG_RESET;
        end
        else if (I_DIAG_VALID)
        begin
            self_diagnostic_result_q <= `SELF_DIAG_RESET;
            self_diagnostic_result_q[`DIAG_REG_LOAD_BIT] <= I_DIAG_REG_LOAD;
            self_diagnostic_result_q[`DIAG_FUNC_BIT] <= I_DIAG_FUNC;
            self_diagnostic_result_q[`DIAG_CHECKSUM_BIT] <= I_DIAG_CHECKSUM_DIFF;
        end
    end

    // ------------------------------------------------------------
    // Read answer
    // ------------------------------------------------------------
    // One-cycle valid; data holds until the next read
    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RST_N)
        begin
            O_RD_VALID <= 1'b0;
            O_RD_DATA <= `SIGNAL_MODE_RESET;
        end
        else if (read_signal_mode_cmd)
        begin
            O_RD_VALID <= 1'b1;
            O_RD_DATA <= signal_mode_status;
        end
        else if (read_self_diag_cmd)
        begin
            O_RD_VALID <= 1'b1;
            O_RD_DATA <= self_diagnostic_result_q;
        end
        else
        begin
            O_RD_VALID <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Sleep entry sequencer
    // ------------------------------------------------------------
    sleep_state_t state_q;
    logic tmr_load;
    logic [TMR_W-1:0] tmr_count;
    logic tmr_expired;
    logic [1:0] frames_q;
    logic blank_time_done_q;
    logic blank_ready;

    // Blanking can end once two frame starts passed and the blank time is up, so a whole frame was blank
    assign blank_ready = (frames_q == FRAMES_NEEDED);

    // Frame starts seen while the sources are blanked
    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RST_N || state_q != ST_BLANK)
            frames_q <= '0;
        else if (frame_start && !blank_ready)
            frames_q <= frames_q + 1'b1;
    end

    // State transitions; during entry only software reset is acted on, forcing sleep
    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RST_N || sw_reset_cmd)
        begin
            state_q <= ST_ASLEEP;
            blank_time_done_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_ASLEEP:
                    if (sleep_exit_cmd)
                        state_q <= ST_AWAKE;
                ST_AWAKE:
                begin
                    if (sleep_entry_cmd)
                    begin
                        state_q <= ST_BLANK;
                        blank_time_done_q <= 1'b0;
                    end
                end
                ST_BLANK:
                begin
                    if (tmr_expired)
                        blank_time_done_q <= 1'b1;
                    // Without pixel frames the second blank period stands in
                    if ((blank_time_done_q || tmr_expired) &&
                        (blank_ready || (blank_time_done_q && tmr_expired)))
                        state_q <= ST_DRAIN;
                end
                ST_DRAIN:
                    if (tmr_expired)
                        state_q <= ST_DCDC_OFF;
                ST_DCDC_OFF:
                    if (tmr_expired)
                        state_q <= ST_OSC_OFF;
                ST_OSC_OFF:
                    if (tmr_expired)
                        state_q <= ST_ASLEEP;
                default:
                    state_q <= ST_ASLEEP;
            endcase
        end
    end

    // Phase timer loads at each step of the entry sequence
    always_comb
    begin
        tmr_load = 1'b0;
        tmr_count = BLANK_LOAD;
        if (I_RST_N && !sw_reset_cmd)
        begin
            case (state_q)
                ST_AWAKE:
                    tmr_load = sleep_entry_cmd;
                ST_BLANK:
                begin
                    // Second blank period when no frames came; drain once both are done
                    tmr_load = tmr_expired || (blank_time_done_q && blank_ready);
                    tmr_count = (blank_ready || blank_time_done_q) ? DRAIN_LOAD : BLANK_LOAD;
                end
                ST_DRAIN:
                begin
                    tmr_load = tmr_expired;
                    tmr_count = DCDC_LOAD;
                end
                ST_DCDC_OFF:
                begin
                    tmr_load = tmr_expired;
                    tmr_count = OSC_LOAD;
                end
                default:
                    tmr_load = 1'b0;
            endcase
        end
    end

    sleep_delay_timer
    #(
        .COUNT_W(TMR_W),
        .TICK_DIV(TICK_DIV)
    )
    u_phase_timer
    (
        .i_clk(I_CLOCK),
        .i_rst_n(I_RST_N),
        .i_load(tmr_load),
        .i_count(tmr_count),
        .o_expired(tmr_expired)
    );

    // ------------------------------------------------------------
    // Power and panel outputs
    // ------------------------------------------------------------
    // Converter runs until drain ends; oscillator until its own step
    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RST_N)
        begin
            O_DCDC_EN <= 1'b0;
            O_OSC_EN <= 1'b0;
            O_SCAN_EN <= 1'b0;
        end
        else
        begin
            O_DCDC_EN <= (state_q == ST_AWAKE) || (state_q == ST_BLANK) ||
                         (state_q == ST_DRAIN);
            O_OSC_EN <= (state_q != ST_ASLEEP) && (state_q != ST_OSC_OFF);
            O_SCAN_EN <= (state_q == ST_AWAKE) || (state_q == ST_BLANK) ||
                         (state_q == ST_DRAIN);
        end
    end

    // Blanking forced whatever the display on/off setting says
    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RST_N)
        begin
            O_SOURCE_BLANK <= 1'b1;
            O_PANEL_DRAIN <= 1'b0;
        end
        else
        begin
            O_SOURCE_BLANK <= (state_q != ST_AWAKE);
            O_PANEL_DRAIN <= (state_q == ST_DRAIN);
        end
    end

    // Power state flags
    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RST_N)
        begin
            O_ASLEEP <= 1'b1;
            O_SLEEP_BUSY <= 1'b0;
        end
        else
        begin
            O_ASLEEP <= (state_q == ST_ASLEEP);
            O_SLEEP_BUSY <= (state_q != ST_ASLEEP) && (state_q != ST_AWAKE);
        end
    end

endmodule : status_readback_and_sleep_entry

// ==== bench/status_readback_and_sleep_entry_monitor.sv ====
module status_sleep_monitor
#(
    parameter int unsigned BLANK_US = 3,
    parameter int unsigned DRAIN_US = 2,
    parameter int unsigned DCDC_OFF_US = 2,
    parameter int unsigned OSC_OFF_US = 2,
    parameter int unsigned TICK_DIV = 2
)
(
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    input wire logic I_CMD_VALID,
    input wire logic [7:0] I_CMD_CODE,
    input wire logic O_RD_VALID,
    input wire status_sleep_pkg::status_byte_t O_RD_DATA,
    input wire logic O_DCDC_EN,
    input wire logic O_OSC_EN,
    input wire logic O_SCAN_EN,
    input wire logic O_SOURCE_BLANK,
    input wire logic O_PANEL_DRAIN,
    input wire logic O_ASLEEP,
    input wire logic O_SLEEP_BUSY
);
    timeunit 1ns;
    timeprecision 1ps;
    import status_sleep_pkg::*;
    localparam int SUM_US = int'(BLANK_US + DRAIN_US + DCDC_OFF_US + OSC_OFF_US);
    localparam int ENTRY_MIN = (SUM_US - 4) * int'(TICK_DIV);
    localparam int ENTRY_MAX = (SUM_US + int'(BLANK_US) + 4) * int'(TICK_DIV) + 10;
    logic [31:0] busy_cnt_q;

    // ------------------------------------------------------------
    // Entry length
    // ------------------------------------------------------------
    // Cycles spent in the current entry
    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RST_N || !O_SLEEP_BUSY)
            busy_cnt_q <= 32'h0;
        else
            busy_cnt_q <= busy_cnt_q + 32'h1;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_RST_N);

    a_read_answer: assert property (
        I_CMD_VALID && (I_CMD_CODE == 8'h0e || I_CMD_CODE == 8'h0f) |=> O_RD_VALID)
        else $error("read not answered");
    a_no_stray_answer: assert property (
        O_RD_VALID |-> $past(I_CMD_VALID) && ($past(I_CMD_CODE) inside {8'h0e, 8'h0f}))
        else $error("answer without read");
    a_mode_zero_bits: assert property (
        O_RD_VALID && $past(I_CMD_CODE) == 8'h0e |-> O_RD_DATA[7:6] == 2'b00 && !O_RD_DATA[1])
        else $error("signal mode fixed bits set");
    a_diag_zero_bits: assert property (
        O_RD_VALID && $past(I_CMD_CODE) == 8'h0f |-> O_RD_DATA[5:1] == 5'h00)
        else $error("diagnostic fixed bits set");
    a_sleep_power_off: assert property (
        O_ASLEEP |-> !(O_DCDC_EN || O_OSC_EN || O_SCAN_EN))
        else $error("power on while asleep");
    a_entry_starts: assert property (
        I_CMD_VALID && I_CMD_CODE == 8'h10 && !O_ASLEEP && !O_SLEEP_BUSY
        |-> ##2 (O_SOURCE_BLANK && O_SLEEP_BUSY))
        else $error("entry did not blank");
    a_entry_ignored: assert property (
        O_ASLEEP && !O_SLEEP_BUSY && !$past(I_CMD_VALID) && I_CMD_VALID
        && I_CMD_CODE == 8'h10 |=> ##1 (O_ASLEEP && !O_SLEEP_BUSY) [*4])
        else $error("entry acted while asleep");
    a_drain_in_order: assert property (
        $rose(O_PANEL_DRAIN) |-> O_SOURCE_BLANK && O_DCDC_EN && O_OSC_EN)
        else $error("drain out of order");
    a_dcdc_after_drain: assert property (
        $fell(O_DCDC_EN) && O_SLEEP_BUSY |-> $past(O_PANEL_DRAIN) && O_SOURCE_BLANK && O_OSC_EN)
        else $error("converter stopped early");
    a_osc_last: assert property (
        $fell(O_OSC_EN) && O_SLEEP_BUSY |-> !O_DCDC_EN && !O_SCAN_EN && !O_PANEL_DRAIN)
        else $error("oscillator stopped early");
    a_entry_bounded: assert property (
        busy_cnt_q <= 32'(ENTRY_MAX))
        else $error("entry too long");
    a_entry_not_early: assert property (
        $fell(O_SLEEP_BUSY) && O_ASLEEP && !$past(O_OSC_EN) && !$past(O_DCDC_EN)
        |-> busy_cnt_q >= 32'(ENTRY_MIN))
        else $error("entry too short");
    a_swreset_sleeps: assert property (
        I_CMD_VALID && I_CMD_CODE == 8'h01 |=> ##1 (O_ASLEEP && !O_DCDC_EN && !O_SLEEP_BUSY))
        else $error("software reset not asleep");
endmodule : status_sleep_monitor

bind status_readback_and_sleep_entry status_sleep_monitor #(
    .BLANK_US(BLANK_US), .DRAIN_US(DRAIN_US), .DCDC_OFF_US(DCDC_OFF_US),
    .OSC_OFF_US(OSC_OFF_US), .TICK_DIV(TICK_DIV)
) u_monitor (
    .I_CLOCK, .I_RST_N, .I_CMD_VALID, .I_CMD_CODE, .O_RD_VALID, .O_RD_DATA, .O_DCDC_EN,
    .O_OSC_EN, .O_SCAN_EN, .O_SOURCE_BLANK, .O_PANEL_DRAIN, .O_ASLEEP, .O_SLEEP_BUSY
);

// ==== bench/host_command_model.sv ====
module host_command_model
#(
    parameter int ENTRY_GAP = 60,
    parameter int EXIT_GAP = 60
)
(
    input wire logic i_clk,
    output logic o_cmd_valid,
    output logic [7:0] o_cmd_code
);
    timeunit 1ns;
    timeprecision 1ps;
    int since_entry_q = 1000;
    int since_exit_q = 1000;

    initial
    begin
        o_cmd_valid = 1'b0;
        o_cmd_code = 8'h5a;
    end

    // Cycles since the last sleep entry and sleep exit
    always @(posedge i_clk)
    begin
        since_entry_q <= (o_cmd_valid && o_cmd_code == 8'h10) ? 0 : since_entry_q + 1;
        since_exit_q <= (o_cmd_valid && o_cmd_code == 8'h11) ? 0 : since_exit_q + 1;
    end

    // One command strobe, after the host-side waits and some slack
    task automatic send(input logic [7:0] code, input int slack);
        while (since_entry_q < ENTRY_GAP)
            @(posedge i_clk);
        while (code == 8'h10 && since_exit_q < EXIT_GAP)
            @(posedge i_clk);
        repeat (slack + 1) @(posedge i_clk);
        o_cmd_valid <= 1'b1;
        o_cmd_code <= code;
        @(posedge i_clk);
        o_cmd_valid <= 1'b0;
        o_cmd_code <= ~code; // Idle bus shows no stale code
    endtask : send
endmodule : host_command_model

// ==== bench/test_status_readback_and_sleep_entry.sv ====
`define CHECK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("[ERR] %0t got %h expected %h", $time, got, exp); \
        end \
    end

module test_status_readback_and_sleep_entry;
    timeunit 1ns;
    timeprecision 1ps;
    import status_sleep_pkg::*;
    localparam int BL = 3;
    localparam int DR = 2;
    localparam int DC = 2;
    localparam int OS = 2;
    localparam int TD = 2;
    localparam int ENTRY_MIN = (BL + DR + DC + OS - 4) * TD;
    localparam int ENTRY_MAX = (2 * BL + DR + DC + OS + 4) * TD + 10;
    logic I_CLOCK, I_RST_N, I_CMD_VALID, I_HSYNC, I_VSYNC, I_PCLK, I_DE;
    logic I_DIAG_VALID, I_DIAG_REG_LOAD, I_DIAG_FUNC, I_DIAG_CHECKSUM_DIFF;
    logic O_RD_VALID, O_DCDC_EN, O_OSC_EN, O_SCAN_EN, O_SOURCE_BLANK;
    logic O_PANEL_DRAIN, O_ASLEEP, O_SLEEP_BUSY;
    logic [7:0] I_CMD_CODE;
    status_byte_t O_RD_DATA, d;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycle_cnt = 0;

    host_command_model host (.i_clk(I_CLOCK), .o_cmd_valid(I_CMD_VALID),
        .o_cmd_code(I_CMD_CODE));
    status_readback_and_sleep_entry #(.BLANK_US(BL), .DRAIN_US(DR), .DCDC_OFF_US(DC),
        .OSC_OFF_US(OS), .TICK_DIV(TD)) dut (.I_CLOCK, .I_RST_N, .I_CMD_VALID, .I_CMD_CODE,
        .I_HSYNC, .I_VSYNC, .I_PCLK, .I_DE, .I_DIAG_VALID, .I_DIAG_REG_LOAD, .I_DIAG_FUNC,
        .I_DIAG_CHECKSUM_DIFF, .O_RD_VALID, .O_RD_DATA, .O_DCDC_EN, .O_OSC_EN, .O_SCAN_EN,
        .O_SOURCE_BLANK, .O_PANEL_DRAIN, .O_ASLEEP, .O_SLEEP_BUSY);

    // ------------------------------------------------------------
    // Shared steps
    // ------------------------------------------------------------
    // 25 ns clock
    initial
    begin
        I_CLOCK = 1'b0;
        forever #12.5 I_CLOCK = ~I_CLOCK;
    end

    // Hang guard
    always @(posedge I_CLOCK)
    begin
        cycle_cnt++;
        if (cycle_cnt == 5000)
        begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic read_byte(input logic [7:0] code, output status_byte_t data);
        host.send(code, 0);
        #1;
        `CHECK(O_RD_VALID, 1'b1)
        data = O_RD_DATA;
    endtask : read_byte

    task automatic set_pins(input logic [3:0] p);
        @(posedge I_CLOCK);
        {I_HSYNC, I_VSYNC, I_PCLK, I_DE} <= p;
        repeat (3) @(posedge I_CLOCK);
    endtask : set_pins

    task automatic set_diag(input logic [2:0] v);
        @(posedge I_CLOCK);
        I_DIAG_VALID <= 1'b1;
        {I_DIAG_REG_LOAD, I_DIAG_FUNC, I_DIAG_CHECKSUM_DIFF} <= v;
        @(posedge I_CLOCK);
        I_DIAG_VALID <= 1'b0;
    endtask : set_diag

    task automatic wake();
        host.send(8'h11, 2);
        repeat (2) @(posedge I_CLOCK);
        #1;
        `CHECK({O_ASLEEP, O_DCDC_EN, O_OSC_EN, O_SCAN_EN, O_SOURCE_BLANK}, 5'b01110)
    endtask : wake

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        read_byte(8'h0e, d);
        `CHECK(d, 8'h00)
        read_byte(8'h0f, d);
        `CHECK(d, 8'h00)
        `CHECK({O_ASLEEP, O_DCDC_EN, O_OSC_EN, O_SCAN_EN}, 4'b1000)
        $display("test reset done");
    endtask : test_reset

    task automatic test_signal_mode();
        for (int i = 0; i < 16; i++)
        begin
            set_pins(4'(i));
            read_byte(8'h0e, d);
            `CHECK(d, {2'b00, 4'(i), 2'b00})
        end
        $display("test signal mode done");
    endtask : test_signal_mode

    task automatic test_diag();
        for (int i = 0; i < 8; i++)
        begin
            set_diag(3'(i));
            read_byte(8'h0f, d);
            `CHECK(d, {i[2], i[1], 5'h00, i[0]})
        end
        $display("test diagnostic done");
    endtask : test_diag

    task automatic test_sleep_entry();
        int t_drain = 1000, t_dcdc = 1000, t_osc = 1000, t_sleep = 1000;
        int rises = 0;
        wake();
        set_pins(4'ha);
        read_byte(8'h0e, d);
        `CHECK(d, 8'h28)
        set_pins(4'h0);
        host.send(8'h10, 0);
        repeat (2) @(posedge I_CLOCK);
        #1;
        `CHECK({O_SOURCE_BLANK, O_SLEEP_BUSY}, 2'b11)
        for (int c = 0; c < 200 && t_sleep == 1000; c++)
        begin
            @(posedge I_CLOCK);
            I_VSYNC <= ~I_VSYNC;
            #1;
            if (I_VSYNC && O_DCDC_EN && O_SOURCE_BLANK)
                rises++;
            if (O_PANEL_DRAIN && t_drain == 1000)
                t_drain = c;
            if (!O_DCDC_EN && t_dcdc == 1000)
                t_dcdc = c;
            if (!O_OSC_EN && t_osc == 1000)
                t_osc = c;
            if (O_ASLEEP)
                t_sleep = c;
        end
        `CHECK(t_drain < t_dcdc && t_dcdc < t_osc && t_osc < t_sleep, 1'b1)
        `CHECK(rises >= 2, 1'b1)
        `CHECK(t_sleep >= ENTRY_MIN && t_sleep <= ENTRY_MAX, 1'b1)
        `CHECK({O_DCDC_EN, O_OSC_EN, O_SCAN_EN, O_SLEEP_BUSY}, 4'b0000)
        @(posedge I_CLOCK);
        I_VSYNC <= 1'b0;
        $display("test sleep entry done");
    endtask : test_sleep_entry

    task automatic test_ignored_entry();
        host.send(8'h10, 1);
        repeat (6)
        begin
            @(posedge I_CLOCK);
            #1;
            `CHECK({O_ASLEEP, O_SLEEP_BUSY, O_DCDC_EN}, 3'b100)
        end
        $display("test ignored entry done");
    endtask : test_ignored_entry

    task automatic test_sw_reset();
        set_diag(3'h7);
        wake();
        host.send(8'h01, 0);
        repeat (2) @(posedge I_CLOCK);
        #1;
        `CHECK({O_ASLEEP, O_DCDC_EN, O_SCAN_EN}, 3'b100)
        read_byte(8'h0f, d);
        `CHECK(d, 8'h00)
        $display("test software reset done");
    endtask : test_sw_reset

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    // Main sequence
    initial
    begin
        I_RST_N = 1'b0;
        {I_HSYNC, I_VSYNC, I_PCLK, I_DE} = 4'h0;
        {I_DIAG_VALID, I_DIAG_REG_LOAD, I_DIAG_FUNC, I_DIAG_CHECKSUM_DIFF} = 4'h0;
        repeat (3) @(posedge I_CLOCK);
        I_RST_N <= 1'b1;
        test_reset();
        test_signal_mode();
        test_diag();
        test_sleep_entry();
        test_ignored_entry();
        test_sw_reset();
        conclude();
    end
endmodule : test_status_readback_and_sleep_entry
